//--- common/tcd_pkg.sv
package tcd_pkg;

	// ----------------------------------------
	// Clock and resonator timing
	// ----------------------------------------
	localparam int CLK_HZ = 125000000;
	localparam int RES_HZ = 480000;
	localparam int DIV_W = 9;
	localparam logic [DIV_W-1:0] RES_DIV_LAST = DIV_W'(CLK_HZ / RES_HZ - 1);

	// ----------------------------------------
	// Tone frequencies and half periods in resonator ticks
	// ----------------------------------------
	localparam int F_L1_HZ = 697;
	localparam int F_L2_HZ = 770;
	localparam int F_L3_HZ = 825;
	localparam int F_L4_HZ = 941;
	localparam int F_H1_HZ = 1209;
	localparam int F_H2_HZ = 1336;
	localparam int F_H3_HZ = 1477;
	localparam int F_ALO_A_HZ = 1200;
	localparam int F_ALO_B_HZ = 1500;
	localparam int F_AHI_A_HZ = 1800;
	localparam int F_AHI_B_HZ = 2250;
	localparam int F_WARBLE_HZ = 20;
	localparam logic [DIV_W-1:0] HALF_L1 = DIV_W'(RES_HZ / (2 * F_L1_HZ));
	localparam logic [DIV_W-1:0] HALF_L2 = DIV_W'(RES_HZ / (2 * F_L2_HZ));
	localparam logic [DIV_W-1:0] HALF_L3 = DIV_W'(RES_HZ / (2 * F_L3_HZ));
	localparam logic [DIV_W-1:0] HALF_L4 = DIV_W'(RES_HZ / (2 * F_L4_HZ));
	localparam logic [DIV_W-1:0] HALF_H1 = DIV_W'(RES_HZ / (2 * F_H1_HZ));
	localparam logic [DIV_W-1:0] HALF_H2 = DIV_W'(RES_HZ / (2 * F_H2_HZ));
	localparam logic [DIV_W-1:0] HALF_H3 = DIV_W'(RES_HZ / (2 * F_H3_HZ));
	localparam logic [DIV_W-1:0] HALF_ALO_A = DIV_W'(RES_HZ / (2 * F_ALO_A_HZ));
	localparam logic [DIV_W-1:0] HALF_ALO_B = DIV_W'(RES_HZ / (2 * F_ALO_B_HZ));
	localparam logic [DIV_W-1:0] HALF_AHI_A = DIV_W'(RES_HZ / (2 * F_AHI_A_HZ));
	localparam logic [DIV_W-1:0] HALF_AHI_B = DIV_W'(RES_HZ / (2 * F_AHI_B_HZ));
	localparam int WARBLE_TICKS_DEF = RES_HZ / (2 * F_WARBLE_HZ);

	// ----------------------------------------
	// Ringer qualification
	// ----------------------------------------
	localparam int RING_THRESH_DEF = 64;
	localparam int RING_W_DEF = 8;

	// ----------------------------------------
	// Code patterns on bits 3..0, special low pattern on bits 1..0
	// ----------------------------------------
	localparam logic [1:0] SPECIAL_LOW = 2'h3;
	localparam logic [3:0] CODE_SPEECH_MUTE = 4'h3;
	localparam logic [3:0] CODE_SPEECH = 4'h7;
	localparam logic [3:0] CODE_DIAL_NT = 4'hb;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_ONHOOK = 3'h1,
		ST_SPEECH = 3'h2,
		ST_DIAL = 3'h4
	} tcd_state_type;

	typedef struct packed {
		logic tone;
		logic dialNt;
		logic speech;
		logic muteReq;
		logic [3:0] low;
		logic [2:0] high;
	} tcd_dec_type;

endpackage

//--- src/tcd_tone_div.sv
`timescale 1ns/100ps
module tcd_tone_div #(
	parameter int W = 9
)(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Control
	input wire logic tick,
	input wire logic enable,
	input wire logic [W-1:0] halfCount,
	// Square wave
	output logic wave
);

	logic [W-1:0] cnt_ff;
	logic wave_ff;
	wire [W-1:0] cntInc = cnt_ff + W'(1);
	wire lastTick = cntInc >= halfCount;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cnt_ff <= '0;
			wave_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (!enable)
			begin
				cnt_ff <= '0;
				wave_ff <= 1'b0;
			end
			else if (tick)
			begin
				cnt_ff <= lastTick ? '0 : cntInc;
				wave_ff <= lastTick ? ~wave_ff : wave_ff;
			end
		end
	end

	assign wave = wave_ff;

endmodule

//--- src/tcd_decoder.sv
// What this block does
// - Code 1000x selects single low tone 1, 697 Hz.
// - Code 1010x selects single low tone 2, 770 Hz.
// - Code 11010 selects single low tone 3, 825 Hz.
// - Code 11110 selects single low tone 4, 941 Hz.
// - Code 11x00 selects single high tone 1, 1209 Hz.
// - Code 11x01 selects single high tone 2, 1336 Hz.
// - Code 10x10 selects single high tone 3, 1477 Hz.
// - Codes x0011 and x0111 give speech with and without transmit mute, no tone.
// - Code x1011 enters dial mode with no tone, dial paths kept.
// - Transmit mute is separate from receive mute, set only by code.
// - Transmit mute request ignored in speech-only low-power operation.
// - Dialing switches tone converter into transmit and attenuates receive path.
// - Decoded codes become timed control signals to the tone converter.
// - Ringer qualifies ringing with an up/down counter on signal magnitude.
// - Alerter outputs run only after a positive ringing decision.
// - All timing derives from a 480 kHz resonator rate.
// - Host sets code bits then strobes; capture on strobe rising edge.
// - Code inputs disabled on-hook and in low-power mode.
// - Pitch select low picks 1200/1500 Hz, high picks 1800/2250 Hz.
// - Feature flag pulled to ground off-hook, released in low-power mode.
`timescale 1ns/100ps
module tcd_decoder #(
	parameter int WARBLE_TICKS = tcd_pkg::WARBLE_TICKS_DEF,
	parameter int RING_THRESH = tcd_pkg::RING_THRESH_DEF,
	parameter int RING_W = tcd_pkg::RING_W_DEF
)(
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	// Microprocessor code port
	input wire logic codeBit4,
	input wire logic codeBit3,
	input wire logic codeBit2,
	input wire logic codeBit1,
	input wire logic codeBit0,
	input wire logic codeStrobe,
	// Line status
	input wire logic hookSense,
	input wire logic lowPowerMode,
	input wire logic ringAbove,
	input wire logic rxMuteReq,
	input wire logic alerterPitchSelect,
	// Tone converter control
	output logic [3:0] lowToneSel,
	output logic [2:0] highToneSel,
	output logic lowToneWave,
	output logic highToneWave,
	output logic toneOn,
	// Path switches
	output logic txToneSwitch,
	output logic rxAttenuate,
	output logic txMute,
	output logic rxMute,
	// Feature flag, open drain
	output logic featureLevelFlagOut,
	output logic featureLevelFlagOe,
	// Alerter
	output logic alerterOutA,
	output logic alerterOutB,
	output logic ringDetected
);
	import tcd_pkg::*;

	// ----------------------------------------
	// Resonator rate tick
	// ----------------------------------------
	logic [DIV_W-1:0] resCnt_ff;
	wire resTick = resCnt_ff == RES_DIV_LAST;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			resCnt_ff <= '0;
		else if (ce)
			resCnt_ff <= resTick ? '0 : resCnt_ff + DIV_W'(1);
	end

	// ----------------------------------------
	// Code capture
	// ----------------------------------------
	logic strobe_ff;
	logic [4:0] code_ff;
	wire [4:0] codeIn = {codeBit4, codeBit3, codeBit2, codeBit1, codeBit0};
	wire strobeRise = codeStrobe & ~strobe_ff;
	wire codeEnable = hookSense & ~lowPowerMode;
	wire accept = strobeRise & codeEnable;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			strobe_ff <= 1'b0;
			code_ff <= 5'h00;
		end
		else if (ce)
		begin
			strobe_ff <= codeStrobe;
			if (accept)
				code_ff <= codeIn;
		end
	end

	// ----------------------------------------
	// Code decode
	// ----------------------------------------
	wire special = codeIn[1:0] == SPECIAL_LOW;
	wire pairSel = ~codeIn[4] & ~special;
	wire selL1 = codeIn[4] & (codeIn[3:1] == 3'h0);
	wire selL2 = codeIn[4] & (codeIn[3:1] == 3'h2);
	wire selL3 = codeIn == 5'h1a;
	wire selL4 = codeIn == 5'h1e;
	wire selH1 = codeIn[4] & codeIn[3] & (codeIn[1:0] == 2'h0);
	wire selH2 = codeIn[4] & codeIn[3] & (codeIn[1:0] == 2'h1);
	wire selH3 = codeIn[4] & ~codeIn[3] & (codeIn[1:0] == 2'h2);
	wire [3:0] lowOne = 4'h1 << codeIn[3:2];
	wire [2:0] highOne = 3'h1 << codeIn[1:0];
	wire [3:0] decLow = pairSel ? lowOne : {selL4, selL3, selL2, selL1};
	wire [2:0] decHigh = pairSel ? highOne : {selH3, selH2, selH1};
	wire isMuteSp = codeIn[3:0] == CODE_SPEECH_MUTE;
	wire isSpeech = codeIn[3:0] == CODE_SPEECH;
	wire isDialNt = codeIn[3:0] == CODE_DIAL_NT;
	tcd_dec_type dec;
	assign dec = '{
		tone: (|decLow) | (|decHigh),
		dialNt: isDialNt,
		speech: isMuteSp | isSpeech,
		muteReq: isMuteSp,
		low: decLow,
		high: decHigh
	};

	// ----------------------------------------
	// Operating mode
	// ----------------------------------------
	tcd_state_type state_ff, nxt_state;

	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_ONHOOK:
				nxt_state = ST_SPEECH;
			ST_SPEECH:
				if (accept && (dec.tone || dec.dialNt))
					nxt_state = ST_DIAL;
			ST_DIAL:
				if (accept && dec.speech)
					nxt_state = ST_SPEECH;
		endcase
		if (!hookSense)
			nxt_state = ST_ONHOOK;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			state_ff <= ST_ONHOOK;
		else if (ce)
			state_ff <= nxt_state;
	end

	// ----------------------------------------
	// Tone selection and path control
	// ----------------------------------------
	logic [3:0] lowSel_ff;
	logic [2:0] highSel_ff;
	logic toneOn_ff, txMute_ff, rxMute_ff, txTone_ff, rxAtten_ff, fmOe_ff, fmOut_ff;
	wire inDial = state_ff == ST_DIAL;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			lowSel_ff <= 4'h0;
			highSel_ff <= 3'h0;
			toneOn_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (!hookSense)
			begin
				lowSel_ff <= 4'h0;
				highSel_ff <= 3'h0;
				toneOn_ff <= 1'b0;
			end
			else if (accept)
			begin
				lowSel_ff <= dec.low;
				highSel_ff <= dec.high;
				toneOn_ff <= dec.tone;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			txMute_ff <= 1'b0;
		else if (ce)
		begin
			if (!hookSense || lowPowerMode)
				txMute_ff <= 1'b0;
			else if (accept && dec.speech)
				txMute_ff <= dec.muteReq;
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			rxMute_ff <= 1'b0;
			txTone_ff <= 1'b0;
			rxAtten_ff <= 1'b0;
			fmOe_ff <= 1'b0;
			fmOut_ff <= 1'b0;
		end
		else if (ce)
		begin
			rxMute_ff <= hookSense & rxMuteReq;
			txTone_ff <= inDial;
			rxAtten_ff <= inDial;
			fmOe_ff <= codeEnable;
			fmOut_ff <= 1'b0;
		end
	end

	// ----------------------------------------
	// Tone dividers
	// ----------------------------------------
	wire [DIV_W-1:0] lowHalf = lowSel_ff[0] ? HALF_L1 : lowSel_ff[1] ? HALF_L2 : lowSel_ff[2] ? HALF_L3 : HALF_L4;
	wire [DIV_W-1:0] highHalf = highSel_ff[0] ? HALF_H1 : highSel_ff[1] ? HALF_H2 : HALF_H3;
	wire lowRun = toneOn_ff & (|lowSel_ff);
	wire highRun = toneOn_ff & (|highSel_ff);

	tcd_tone_div #(.W(DIV_W)) uLowDiv (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.tick(resTick),
		.enable(lowRun),
		.halfCount(lowHalf),
		.wave(lowToneWave)
	);

	tcd_tone_div #(.W(DIV_W)) uHighDiv (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.tick(resTick),
		.enable(highRun),
		.halfCount(highHalf),
		.wave(highToneWave)
	);

	// ----------------------------------------
	// Ringer qualification
	// ----------------------------------------
	localparam logic [RING_W-1:0] RING_TOP = RING_W'(RING_THRESH);
	localparam logic [RING_W-1:0] RING_PRE = RING_W'(RING_THRESH - 1);
	localparam int WB_W = $clog2(WARBLE_TICKS + 1);
	localparam logic [WB_W-1:0] WB_LAST = WB_W'(WARBLE_TICKS - 1);
	logic [RING_W-1:0] ringCnt_ff;
	logic ringDet_ff;
	wire ringUp = resTick & ringAbove & (ringCnt_ff != RING_TOP);
	wire ringDn = resTick & ~ringAbove & (ringCnt_ff != '0);
	wire ringSet = ringUp & (ringCnt_ff == RING_PRE);
	wire ringClr = ringDn & (ringCnt_ff == RING_W'(1));

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ringCnt_ff <= '0;
			ringDet_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (hookSense)
			begin
				ringCnt_ff <= '0;
				ringDet_ff <= 1'b0;
			end
			else
			begin
				if (ringUp)
					ringCnt_ff <= ringCnt_ff + RING_W'(1);
				else if (ringDn)
					ringCnt_ff <= ringCnt_ff - RING_W'(1);
				if (ringSet)
					ringDet_ff <= 1'b1;
				else if (ringClr)
					ringDet_ff <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Alerter warble
	// ----------------------------------------
	logic [WB_W-1:0] wbCnt_ff;
	logic wbPhase_ff, alA_ff, alB_ff;
	wire alWave;
	wire wbLast = wbCnt_ff == WB_LAST;
	wire [DIV_W-1:0] alLoHalf = wbPhase_ff ? HALF_ALO_B : HALF_ALO_A;
	wire [DIV_W-1:0] alHiHalf = wbPhase_ff ? HALF_AHI_B : HALF_AHI_A;
	wire [DIV_W-1:0] alHalf = alerterPitchSelect ? alHiHalf : alLoHalf;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wbCnt_ff <= '0;
			wbPhase_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (!ringDet_ff)
			begin
				wbCnt_ff <= '0;
				wbPhase_ff <= 1'b0;
			end
			else if (resTick)
			begin
				wbCnt_ff <= wbLast ? '0 : wbCnt_ff + WB_W'(1);
				wbPhase_ff <= wbLast ? ~wbPhase_ff : wbPhase_ff;
			end
		end
	end

	tcd_tone_div #(.W(DIV_W)) uAlertDiv (
		.clk_sys(clk_sys),
		.rst(rst),
		.ce(ce),
		.tick(resTick),
		.enable(ringDet_ff),
		.halfCount(alHalf),
		.wave(alWave)
	);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			alA_ff <= 1'b0;
			alB_ff <= 1'b0;
		end
		else if (ce)
		begin
			alA_ff <= ringDet_ff & alWave;
			alB_ff <= ringDet_ff & ~alWave;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign lowToneSel = lowSel_ff;
	assign highToneSel = highSel_ff;
	assign toneOn = toneOn_ff;
	assign txToneSwitch = txTone_ff;
	assign rxAttenuate = rxAtten_ff;
	assign txMute = txMute_ff;
	assign rxMute = rxMute_ff;
	assign featureLevelFlagOut = fmOut_ff;
	assign featureLevelFlagOe = fmOe_ff;
	assign alerterOutA = alA_ff;
	assign alerterOutB = alB_ff;
	assign ringDetected = ringDet_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_single_low1: assert property (ce && accept && codeIn[4:1] == 4'h8 |=> toneOn_ff && lowSel_ff == 4'h1 && highSel_ff == 3'h0)
		else $error("single low tone 1 not selected");
	a_single_high3: assert property (ce && accept && codeIn[4:3] == 2'h2 && codeIn[1:0] == 2'h2 |=> lowSel_ff == 4'h0 && highSel_ff == 3'h4)
		else $error("single high tone 3 not selected");
	a_pair_decode: assert property (ce && accept && pairSel |=> toneOn_ff && lowSel_ff == $past(lowOne) && highSel_ff == $past(highOne))
		else $error("tone pair decoded wrongly");
	a_dial_notone: assert property (ce && accept && isDialNt |=> !toneOn_ff && state_ff == ST_DIAL)
		else $error("dial without tone not entered");
	a_invalid_keep: assert property (ce && accept && codeIn[3:0] == 4'hf |=> !toneOn_ff && state_ff == $past(state_ff))
		else $error("unlisted code changed the path");
	a_txmute_lowpwr: assert property (ce && lowPowerMode |=> !txMute_ff)
		else $error("transmit mute active in low power");
	a_dial_paths: assert property (ce && inDial |=> txTone_ff && rxAtten_ff)
		else $error("dial paths not switched");
	a_code_hold: assert property (!codeEnable || !ce |=> $stable(code_ff))
		else $error("code taken while disabled");
	a_strobe_capture: assert property (ce && accept |=> code_ff == $past(codeIn))
		else $error("code not captured on strobe");
	a_ring_decide: assert property (ce && !hookSense && ringSet |=> ringDet_ff)
		else $error("ringing decision missed");
	a_alert_gated: assert property (alA_ff || alB_ff |-> $past(ringDet_ff))
		else $error("alerter active without ringing");
	a_feature_flag: assert property (ce && hookSense && !lowPowerMode |=> fmOe_ff && !fmOut_ff)
		else $error("feature flag not driven low");

	c_tone_dial: cover property (ce && accept && dec.tone);
	c_ring_on: cover property ($rose(ringDet_ff));
	c_mute_on: cover property ($rose(txMute_ff));

endmodule

//--- verification/tcd_host_model.sv
`timescale 1ns/100ps
module tcd_host_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bench command
	input wire logic go,
	input wire logic [4:0] code,
	input wire logic [1:0] slow,
	input wire logic [1:0] hold,
	output logic done,
	// Code port
	output logic [4:0] codeBits,
	output logic codeStrobe
);
	// ----------------------------------------
	// Setup, strobe, release
	// ----------------------------------------
	logic [1:0] phase_ff;
	logic [1:0] cnt_ff;
	logic [4:0] bits_ff;
	logic strobe_ff;
	logic done_ff;

	assign codeBits = bits_ff;
	assign codeStrobe = strobe_ff;
	assign done = done_ff;

	always @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			phase_ff <= 2'h0;
			cnt_ff <= 2'h0;
			bits_ff <= 5'h00;
			strobe_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			if (phase_ff == 2'h0 && go)
			begin
				bits_ff <= code;
				cnt_ff <= slow;
				phase_ff <= 2'h1;
			end
			else if (phase_ff == 2'h1 && cnt_ff == 2'h0)
			begin
				strobe_ff <= 1'b1;
				cnt_ff <= hold;
				phase_ff <= 2'h2;
			end
			else if (phase_ff == 2'h2 && cnt_ff == 2'h0)
			begin
				strobe_ff <= 1'b0;
				bits_ff <= ~bits_ff;
				done_ff <= 1'b1;
				phase_ff <= 2'h0;
			end
			else if (phase_ff != 2'h0)
				cnt_ff <= cnt_ff - 2'h1;
		end
	end
endmodule

//--- verification/tcd_decoder_test.sv
`timescale 1ns/100ps
module tcd_decoder_test;
	import tcd_pkg::*;
	typedef struct packed {
		logic kind;
		logic [15:0] exp;
		logic [15:0] mask;
	} tcd_note_type;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk_sys, rst, ce, hookSense, lowPowerMode, ringAbove, rxMuteReq, alerterPitchSelect;
	logic hostGo, hostDone, codeStrobe, toneOn, txToneSwitch, rxAttenuate, txMute, rxMute;
	logic lowToneWave, highToneWave;
	logic featureLevelFlagOut, featureLevelFlagOe, alerterOutA, alerterOutB, ringDetected, pathNow;
	logic [4:0] hostCode, codeBits;
	logic [1:0] hostSlow, hostHold;
	logic [3:0] lowToneSel;
	logic [2:0] highToneSel;
	int num_errors, cmp_count, cycles, i;
	logic [4:0] base;
	tcd_note_type notes[$];
	tcd_note_type nt;

	tcd_host_model host (.clk_sys(clk_sys), .rst(rst), .go(hostGo), .code(hostCode), .slow(hostSlow),
		.hold(hostHold), .done(hostDone), .codeBits(codeBits), .codeStrobe(codeStrobe));

	tcd_decoder #(.WARBLE_TICKS(4), .RING_THRESH(3)) uut (.clk_sys(clk_sys), .rst(rst), .ce(ce),
		.codeBit4(codeBits[4]), .codeBit3(codeBits[3]), .codeBit2(codeBits[2]), .codeBit1(codeBits[1]),
		.codeBit0(codeBits[0]), .codeStrobe(codeStrobe), .hookSense(hookSense), .lowPowerMode(lowPowerMode),
		.ringAbove(ringAbove), .rxMuteReq(rxMuteReq), .alerterPitchSelect(alerterPitchSelect),
		.lowToneSel(lowToneSel), .highToneSel(highToneSel), .lowToneWave(lowToneWave),
		.highToneWave(highToneWave), .toneOn(toneOn),
		.txToneSwitch(txToneSwitch), .rxAttenuate(rxAttenuate), .txMute(txMute), .rxMute(rxMute),
		.featureLevelFlagOut(featureLevelFlagOut), .featureLevelFlagOe(featureLevelFlagOe),
		.alerterOutA(alerterOutA), .alerterOutB(alerterOutB), .ringDetected(ringDetected));

	// ----------------------------------------
	// Clock, timeout, closing
	// ----------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 15000)
		begin
			num_errors++;
			stop_test();
		end
	end

	// ----------------------------------------
	// Expectations and comparisons
	// ----------------------------------------
	function automatic tcd_note_type code_note(input logic [4:0] c);
		tcd_note_type n;
		logic [3:0] lo;
		logic [2:0] hi;
		logic sp;
		lo = 4'h0;
		hi = 3'h0;
		sp = (c[1:0] == 2'h3);
		if (!sp && !c[4])
		begin
			lo = 4'h1 << c[3:2];
			hi = 3'h1 << c[1:0];
		end
		else if (!sp)
		begin
			lo[0] = (c[3:1] == 3'h0);
			lo[1] = (c[3:1] == 3'h2);
			lo[2] = (c[3:0] == 4'ha);
			lo[3] = (c[3:0] == 4'he);
			hi[0] = c[3] && (c[1:0] == 2'h0);
			hi[1] = c[3] && (c[1:0] == 2'h1);
			hi[2] = !c[3] && (c[1:0] == 2'h2);
		end
		if (!sp || c[3:2] == 2'h2)
			pathNow = 1'b1;
		else if (!c[3])
			pathNow = 1'b0;
		n.kind = 1'b0;
		n.exp = {lo, hi, !sp, sp && !c[3] && !c[2], pathNow, pathNow, rxMuteReq, 1'b1, 1'b0, 2'h0};
		n.mask = (sp && !c[3]) ? 16'hfffc : ((sp && c[2]) ? 16'h017c : 16'hff7c);
		return n;
	endfunction

	task automatic judge(input logic [15:0] got, input tcd_note_type n);
		cmp_count++;
		if ((got & n.mask) !== (n.exp & n.mask))
		begin
			num_errors++;
			$display("MISMATCH at %0t got %h expected %h", $time, got & n.mask, n.exp & n.mask);
		end
	endtask

	task automatic cmp_code(input tcd_note_type n);
		judge({lowToneSel, highToneSel, toneOn, txMute, txToneSwitch, rxAttenuate, rxMute,
			featureLevelFlagOe, featureLevelFlagOut, lowToneWave, highToneWave}, n);
	endtask

	task automatic cmp_ring(input tcd_note_type n);
		judge({ringDetected, alerterOutA ^ alerterOutB, alerterOutA | alerterOutB, 13'h0}, n);
	endtask

	always @(negedge clk_sys)
	begin
		if (notes.size() > 0)
		begin
			nt = notes.pop_front();
			if (nt.kind)
				cmp_ring(nt);
			else
				cmp_code(nt);
		end
	end

	// ----------------------------------------
	// Drivers
	// ----------------------------------------
	task automatic send(input logic [4:0] c);
		int k;
		k = 0;
		hostGo <= 1'b1;
		hostCode <= c;
		hostSlow <= 2'($urandom_range(3));
		hostHold <= 2'($urandom_range(3));
		@(posedge clk_sys);
		hostGo <= 1'b0;
		while (hostDone !== 1'b1 && k < 20)
		begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 20)
			num_errors++;
	endtask

	task automatic ring_note(input logic v);
		notes.push_back('{1'b1, {v, v, v, 13'h0}, 16'he000});
	endtask

	task automatic wait_ring(input logic v);
		int k;
		k = 0;
		while (ringDetected !== v && k < 2000)
		begin
			@(posedge clk_sys);
			k++;
		end
		if (k >= 2000)
			num_errors++;
		repeat (2) @(posedge clk_sys);
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(35));
		rst = 1'b1;
		ce = 1'b1;
		hookSense = 1'b1;
		lowPowerMode = 1'b0;
		ringAbove = 1'b0;
		rxMuteReq = 1'b0;
		alerterPitchSelect = 1'b0;
		hostGo = 1'b0;
		hostCode = 5'h00;
		hostSlow = 2'h0;
		hostHold = 2'h0;
		pathNow = 1'b0;
		num_errors = 0;
		cmp_count = 0;
		cycles = 0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		base = 5'($urandom_range(31));
		for (i = 0; i < 32; i++)
		begin
			rxMuteReq <= 1'($urandom_range(1));
			alerterPitchSelect <= 1'($urandom_range(1));
			send(5'(i) ^ base);
			notes.push_back(code_note(5'(i) ^ base));
		end
		send(5'h03);
		notes.push_back(code_note(5'h03));
		// Strobe while frozen must leave every output as it was
		ce <= 1'b0;
		send(5'h0b);
		ce <= 1'b1;
		notes.push_back(code_note(5'h03));
		lowPowerMode <= 1'b1;
		repeat (3) @(posedge clk_sys);
		send(5'h00);
		notes.push_back('{1'b0, {11'h0, rxMuteReq, 4'h0}, 16'hffff});
		lowPowerMode <= 1'b0;
		hookSense <= 1'b0;
		repeat (3) @(posedge clk_sys);
		send(5'h05);
		notes.push_back('{1'b0, 16'h0000, 16'hffef});
		ringAbove <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ring_note(1'b0);
		wait_ring(1'b1);
		ring_note(1'b1);
		ringAbove <= 1'b0;
		wait_ring(1'b0);
		ring_note(1'b0);
		hookSense <= 1'b1;
		ringAbove <= 1'b1;
		repeat (1500) @(posedge clk_sys);
		ring_note(1'b0);
		ringAbove <= 1'b0;
		repeat (3) @(posedge clk_sys);
		stop_test();
	end
endmodule
